// File: rtl/cwd_config_word_decoder.sv
// Configuration word store, decoder and reset sequencer with AXI4-Lite
// Notes on behaviour
// - A configuration bit reading 0 is programmed, 1 is erased.
// - The configuration word lives at program memory location 2007h.
// - Region 2000h to 3FFFh is reachable only in programming mode.
// - Code protection pair repeats at bits 13-8 and 5-4.
// - Protection 11 off, 10 upper half, 01 upper 3/4, 00 all.
// - Unimplemented configuration bits read back as 1.
// - Brown-out enable bit 1 enables brown-out reset, 0 disables it.
// - Power-up timer enable is active low.
// - Watchdog enable bit 1 enables watchdog, 0 disables it.
// - Oscillator 11 RC, 10 high-speed, 01 standard, 00 low-power.
// - Brown-out enable forces the power-up timer on.
// - Watchdog disabled only by configuration; runs from its own clock.
// - Power-up timer holds reset a nominal 72 ms, on power-up only.
// - Oscillator start-up timer holds reset until crystal is stable.
// - Sleep ends on external reset, watchdog wake-up or interrupt.
//
// Implementation choices: the AXI4-Lite register port and the address map.
`timescale 1ns/1ns
`default_nettype none
module cwd_config_word_decoder #(
  parameter longint POWERUP_DELAY_TIMER_CYCLES = cwd_pkg::POWERUP_DELAY_TIMER_CYCLES,
  parameter int OST_CYCLES = cwd_pkg::OST_CYCLES,
  parameter int TMR_W = 21
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_n_i,
  // AXI4-Lite write
  input wire logic [3:0] s_axi_awaddr_i,
  input wire logic s_axi_awvalid_i,
  output logic s_axi_awready_o,
  input wire logic [31:0] s_axi_wdata_i,
  input wire logic [3:0] s_axi_wstrb_i,
  input wire logic s_axi_wvalid_i,
  output logic s_axi_wready_o,
  output logic [1:0] s_axi_bresp_o,
  output logic s_axi_bvalid_o,
  input wire logic s_axi_bready_i,
  // AXI4-Lite read
  input wire logic [3:0] s_axi_araddr_i,
  input wire logic s_axi_arvalid_i,
  output logic s_axi_arready_o,
  output logic [31:0] s_axi_rdata_o,
  output logic [1:0] s_axi_rresp_o,
  output logic s_axi_rvalid_o,
  input wire logic s_axi_rready_i,
  // Pins and events
  input wire logic prog_mode_i,
  input wire logic ext_reset_i,
  input wire logic brownout_i,
  input wire logic watchdog_timeout_i,
  input wire logic irq_i,
  // Decoded controls
  output logic device_reset_o,
  output logic sleep_o,
  output logic brownout_reset_en_o,
  output logic powerup_timer_on_o,
  output logic watchdog_en_o,
  output logic [1:0] osc_mode_sel_o,
  output logic [1:0] protect_level_o,
  output logic cp_mismatch_o
);
  typedef enum logic [2:0] {
    ST_CAPTURE, ST_POWERUP_DELAY_TIMER, ST_OST, ST_RUN, ST_SLEEP
  } cwd_state_t;

  cwd_state_t state_reg;
  logic [3:0] pins_q;
  logic prog_mode_q, ext_reset_q, brownout_q, wdt_wake_q;
  logic [13:0] word_reg, prog_addr_reg;
  logic power_up_reg;
  logic powerup_delay_timer_start, powerup_delay_timer_busy, powerup_delay_timer_done, ost_start, ost_busy, ost_done;
  logic aw_have_reg, w_have_reg;
  logic [3:0] aw_addr_reg;
  logic [31:0] w_data_reg;
  logic [3:0] w_strb_reg;
  logic wr_fire, rd_fire, in_region, data_ok, sleep_req;
  logic [31:0] rd_word;
  logic [1:0] rd_resp, wr_resp;
  logic [1:0] cp_sel;
  logic cp_same;

  initial
  begin
    if (POWERUP_DELAY_TIMER_CYCLES < 2 || POWERUP_DELAY_TIMER_CYCLES >= (64'd1 << TMR_W))
      $error("POWERUP_DELAY_TIMER_CYCLES does not fit the timer width");
    if (OST_CYCLES < 2 || OST_CYCLES >= (1 << TMR_W))
      $error("OST_CYCLES does not fit the timer width");
  end

  cwd_sync #(.WIDTH(4)) u_sync (
    .clk_i(clk_i),
    .rst_n_i(rst_n_i),
    .async_i({prog_mode_i, ext_reset_i, brownout_i, watchdog_timeout_i}),
    .sync_o(pins_q)
  );
  assign {prog_mode_q, ext_reset_q, brownout_q, wdt_wake_q} = pins_q;

  cwd_delay_timer #(.WIDTH(TMR_W)) u_powerup_delay_timer (
    .clk_i(clk_i),
    .rst_n_i(rst_n_i),
    .start_i(powerup_delay_timer_start),
    .count_i(TMR_W'(POWERUP_DELAY_TIMER_CYCLES)),
    .busy_o(powerup_delay_timer_busy),
    .done_o(powerup_delay_timer_done)
  );

  cwd_delay_timer #(.WIDTH(TMR_W)) u_ost (
    .clk_i(clk_i),
    .rst_n_i(rst_n_i),
    .start_i(ost_start),
    .count_i(TMR_W'(OST_CYCLES)),
    .busy_o(ost_busy),
    .done_o(ost_done)
  );

  // Live word decode; all four protection copies must agree
  assign cp_sel = word_reg[cwd_pkg::CP_PAIR0_LSB +: 2];
  assign cp_same = (word_reg[cwd_pkg::CP_PAIR1_LSB +: 2] == cp_sel) &&
    (word_reg[cwd_pkg::CP_PAIR2_LSB +: 2] == cp_sel) &&
    (word_reg[cwd_pkg::CP_PAIR3_LSB +: 2] == cp_sel);

  // Captured controls; word changes only take hold at the next reset
  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      brownout_reset_en_o <= 1'b0;
      powerup_timer_on_o <= 1'b0;
      watchdog_en_o <= 1'b0;
      osc_mode_sel_o <= 2'h3;
      protect_level_o <= 2'h3;
      cp_mismatch_o <= 1'b0;
    end
    else if (state_reg == ST_CAPTURE)
    begin
      brownout_reset_en_o <= word_reg[cwd_pkg::BIT_BROWNOUT_EN];
      powerup_timer_on_o <= !word_reg[cwd_pkg::BIT_POWERUP_DELAY_TIMER_EN_N] ||
        word_reg[cwd_pkg::BIT_BROWNOUT_EN];
      watchdog_en_o <= word_reg[cwd_pkg::BIT_WATCHDOG_EN];
      osc_mode_sel_o <= word_reg[cwd_pkg::OSC_SEL_LSB +: 2];
      // Mismatched copies select no listed scheme, so none applies
      protect_level_o <= cp_same ? cp_sel : 2'h3;
      cp_mismatch_o <= !cp_same;
    end
  end

  // Reset sequencer
  assign powerup_delay_timer_start = (state_reg == ST_CAPTURE) && power_up_reg &&
    (!word_reg[cwd_pkg::BIT_POWERUP_DELAY_TIMER_EN_N] ||
     word_reg[cwd_pkg::BIT_BROWNOUT_EN]);
  assign ost_start = ((state_reg == ST_CAPTURE) && !powerup_delay_timer_start &&
    word_reg[1:0] != 2'h3) ||
    ((state_reg == ST_POWERUP_DELAY_TIMER) && powerup_delay_timer_done &&
     osc_mode_sel_o != 2'h3) ||
    ((state_reg == ST_SLEEP) && (irq_i || (wdt_wake_q && watchdog_en_o)) &&
     osc_mode_sel_o != 2'h3);
  assign sleep_req = wr_fire && aw_addr_reg == cwd_pkg::OFS_SLEEP_CTRL &&
    w_strb_reg[0] && w_data_reg[0];

  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      state_reg <= ST_CAPTURE;
      power_up_reg <= 1'b1;
    end
    // Held in capture while brown-out lasts, so reset cannot blink off
    else if (ext_reset_q || (brownout_q && brownout_reset_en_o))
      state_reg <= ST_CAPTURE;
    else
    begin
      case (state_reg)
        ST_CAPTURE:
        begin
          if (powerup_delay_timer_start)
            state_reg <= ST_POWERUP_DELAY_TIMER;
          else if (ost_start)
            state_reg <= ST_OST;
          else
            state_reg <= ST_RUN;
          power_up_reg <= 1'b0;
        end
        ST_POWERUP_DELAY_TIMER:
          if (powerup_delay_timer_done)
            state_reg <= ost_start ? ST_OST : ST_RUN;
        ST_OST:
          if (ost_done)
            state_reg <= ST_RUN;
        ST_RUN:
          if (sleep_req)
            state_reg <= ST_SLEEP;
        ST_SLEEP:
          // Watchdog wakes only if configuration enabled it
          if (irq_i || (wdt_wake_q && watchdog_en_o))
            state_reg <= ost_start ? ST_OST : ST_RUN;
        default:
          state_reg <= ST_CAPTURE;
      endcase
    end
  end

  assign device_reset_o = (state_reg == ST_CAPTURE) ||
    (state_reg == ST_POWERUP_DELAY_TIMER) || (state_reg == ST_OST);
  assign sleep_o = (state_reg == ST_SLEEP);

  // Programming access: only 2007h holds storage in the test region
  assign in_region = prog_addr_reg >= cwd_pkg::TEST_REGION_LO &&
    prog_addr_reg <= cwd_pkg::TEST_REGION_HI;
  assign data_ok = prog_mode_q && in_region;

  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      word_reg <= cwd_pkg::CFG_ERASED;
    else if (wr_fire && aw_addr_reg == cwd_pkg::OFS_PROG_DATA && data_ok &&
      prog_addr_reg == cwd_pkg::CFG_WORD_ADDR && w_strb_reg[1:0] == 2'h3)
      word_reg <= w_data_reg[13:0] | cwd_pkg::CFG_UNIMPL_MASK;
  end

  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      prog_addr_reg <= cwd_pkg::PROG_ADDR_RST;
    else if (wr_fire && aw_addr_reg == cwd_pkg::OFS_PROG_ADDR &&
      w_strb_reg[1:0] == 2'h3)
      prog_addr_reg <= w_data_reg[13:0];
  end

  // AXI4-Lite write: address and data taken in either order
  assign s_axi_awready_o = !aw_have_reg && !s_axi_bvalid_o;
  assign s_axi_wready_o = !w_have_reg && !s_axi_bvalid_o;
  assign wr_fire = aw_have_reg && w_have_reg && !s_axi_bvalid_o;

  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      aw_have_reg <= 1'b0;
      w_have_reg <= 1'b0;
      aw_addr_reg <= 4'h0;
      w_data_reg <= 32'h0000_0000;
      w_strb_reg <= 4'h0;
    end
    else
    begin
      if (s_axi_awvalid_i && s_axi_awready_o)
      begin
        aw_have_reg <= 1'b1;
        aw_addr_reg <= s_axi_awaddr_i;
      end
      else if (wr_fire)
        aw_have_reg <= 1'b0;
      if (s_axi_wvalid_i && s_axi_wready_o)
      begin
        w_have_reg <= 1'b1;
        w_data_reg <= s_axi_wdata_i;
        w_strb_reg <= s_axi_wstrb_i;
      end
      else if (wr_fire)
        w_have_reg <= 1'b0;
    end
  end

  always_comb
  begin
    case (aw_addr_reg)
      cwd_pkg::OFS_PROG_ADDR: wr_resp = cwd_pkg::RESP_OKAY;
      cwd_pkg::OFS_PROG_DATA:
        wr_resp = data_ok ? cwd_pkg::RESP_OKAY : cwd_pkg::RESP_SLVERR;
      cwd_pkg::OFS_STATUS: wr_resp = cwd_pkg::RESP_OKAY;
      cwd_pkg::OFS_SLEEP_CTRL: wr_resp = cwd_pkg::RESP_OKAY;
      default: wr_resp = cwd_pkg::RESP_DECERR;
    endcase
  end

  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      s_axi_bvalid_o <= 1'b0;
      s_axi_bresp_o <= cwd_pkg::RESP_OKAY;
    end
    else if (wr_fire)
    begin
      s_axi_bvalid_o <= 1'b1;
      s_axi_bresp_o <= wr_resp;
    end
    else if (s_axi_bready_i)
      s_axi_bvalid_o <= 1'b0;
  end

  // AXI4-Lite read: answered one cycle after the address is taken
  assign s_axi_arready_o = !s_axi_rvalid_o;
  assign rd_fire = s_axi_arvalid_i && s_axi_arready_o;

  always_comb
  begin
    rd_word = 32'h0000_0000;
    rd_resp = cwd_pkg::RESP_OKAY;
    case (s_axi_araddr_i)
      cwd_pkg::OFS_PROG_ADDR: rd_word[13:0] = prog_addr_reg;
      cwd_pkg::OFS_PROG_DATA:
        if (!data_ok)
          rd_resp = cwd_pkg::RESP_SLVERR;
        else if (prog_addr_reg == cwd_pkg::CFG_WORD_ADDR)
          rd_word[13:0] = word_reg | cwd_pkg::CFG_UNIMPL_MASK;
        else
          rd_word[13:0] = cwd_pkg::CFG_ERASED;
      cwd_pkg::OFS_STATUS:
        rd_word[11:0] = {prog_mode_q, sleep_o, device_reset_o, cp_mismatch_o,
          protect_level_o, brownout_reset_en_o, powerup_timer_on_o,
          watchdog_en_o, osc_mode_sel_o, 1'b0};
      cwd_pkg::OFS_SLEEP_CTRL: rd_word[0] = sleep_o;
      default: rd_resp = cwd_pkg::RESP_DECERR;
    endcase
  end

  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      s_axi_rvalid_o <= 1'b0;
      s_axi_rdata_o <= 32'h0000_0000;
      s_axi_rresp_o <= cwd_pkg::RESP_OKAY;
    end
    else if (rd_fire)
    begin
      s_axi_rvalid_o <= 1'b1;
      s_axi_rdata_o <= rd_word;
      s_axi_rresp_o <= rd_resp;
    end
    else if (s_axi_rready_i)
      s_axi_rvalid_o <= 1'b0;
  end

  // Checks
  logic [31:0] powerup_delay_timer_len_reg;
  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      powerup_delay_timer_len_reg <= 32'h0000_0000;
    else if (state_reg == ST_POWERUP_DELAY_TIMER)
      powerup_delay_timer_len_reg <= powerup_delay_timer_len_reg + 32'h0000_0001;
    else
      powerup_delay_timer_len_reg <= 32'h0000_0000;
  end

  property p_word_needs_prog;
    @(posedge clk_i) disable iff (!rst_n_i)
    $changed(word_reg) |-> $past(prog_mode_q);
  endproperty
  a_word_needs_prog: assert property (p_word_needs_prog)
    else $error("configuration word changed outside programming mode");

  property p_unimpl_one;
    @(posedge clk_i) disable iff (!rst_n_i)
    rd_fire && s_axi_araddr_i == cwd_pkg::OFS_PROG_DATA && data_ok &&
    prog_addr_reg == cwd_pkg::CFG_WORD_ADDR |=> s_axi_rdata_o[7];
  endproperty
  a_unimpl_one: assert property (p_unimpl_one)
    else $error("unimplemented bit did not read as one");

  property p_prot_all;
    @(posedge clk_i) disable iff (!rst_n_i)
    state_reg == ST_CAPTURE && !ext_reset_q && word_reg[13:8] == 6'h00 &&
    word_reg[5:4] == 2'h0 |=> protect_level_o == 2'h0 && !cp_mismatch_o;
  endproperty
  a_prot_all: assert property (p_prot_all)
    else $error("all-zero selector did not protect all memory");

  property p_bor_reset;
    @(posedge clk_i) disable iff (!rst_n_i)
    state_reg == ST_RUN && brownout_q && brownout_reset_en_o
    |=> state_reg == ST_CAPTURE ##1 device_reset_o;
  endproperty
  a_bor_reset: assert property (p_bor_reset)
    else $error("brown-out did not reset the device");

  property p_powerup_delay_timer_forced;
    @(posedge clk_i) disable iff (!rst_n_i)
    state_reg == ST_CAPTURE && power_up_reg && !ext_reset_q &&
    !(brownout_q && brownout_reset_en_o) &&
    word_reg[cwd_pkg::BIT_BROWNOUT_EN] |=> state_reg == ST_POWERUP_DELAY_TIMER;
  endproperty
  a_powerup_delay_timer_forced: assert property (p_powerup_delay_timer_forced)
    else $error("brown-out enable did not force the power-up timer");

  property p_powerup_delay_timer_length;
    @(posedge clk_i) disable iff (!rst_n_i)
    state_reg == ST_POWERUP_DELAY_TIMER ##1 state_reg != ST_POWERUP_DELAY_TIMER && !$past(ext_reset_q) &&
    !$past(brownout_q) |-> $past(powerup_delay_timer_len_reg) == 32'(POWERUP_DELAY_TIMER_CYCLES);
  endproperty
  a_powerup_delay_timer_length: assert property (p_powerup_delay_timer_length)
    else $error("power-up timer length wrong");

  property p_ost_hold;
    @(posedge clk_i) disable iff (!rst_n_i)
    state_reg == ST_OST && ost_busy |-> device_reset_o;
  endproperty
  a_ost_hold: assert property (p_ost_hold)
    else $error("reset released before oscillator start-up");

  property p_irq_wake;
    @(posedge clk_i) disable iff (!rst_n_i)
    sleep_o && irq_i |=> !sleep_o;
  endproperty
  a_irq_wake: assert property (p_irq_wake)
    else $error("interrupt did not end sleep");

  property p_held;
    @(posedge clk_i) disable iff (!rst_n_i)
    state_reg != ST_CAPTURE ##1 state_reg != ST_CAPTURE |->
    $stable(osc_mode_sel_o) && $stable(watchdog_en_o) &&
    $stable(protect_level_o);
  endproperty
  a_held: assert property (p_held)
    else $error("decoded controls changed outside reset");

  c_sleep_wake: cover property (@(posedge clk_i) disable iff (!rst_n_i)
    sleep_o ##1 !sleep_o);
  c_word_write: cover property (@(posedge clk_i) disable iff (!rst_n_i)
    $changed(word_reg));
  c_ost_run: cover property (@(posedge clk_i) disable iff (!rst_n_i)
    state_reg == ST_OST ##1 state_reg == ST_RUN);
endmodule
`default_nettype wire

// File: rtl/cwd_pkg.sv
// Constants and types shared by the configuration word decoder
package cwd_pkg;
  // Clock and timing
  localparam longint CLK_HZ = 64'd20_000_000;
  localparam longint POWERUP_DELAY_TIMER_MS = 64'd72;
  localparam longint POWERUP_DELAY_TIMER_CYCLES = (POWERUP_DELAY_TIMER_MS * CLK_HZ) / 64'd1000;
  localparam int OST_CYCLES = 1024;
  // Configuration memory map
  localparam logic [13:0] CFG_WORD_ADDR = 14'h2007;
  localparam logic [13:0] TEST_REGION_LO = 14'h2000;
  localparam logic [13:0] TEST_REGION_HI = 14'h3FFF;
  localparam logic [13:0] CFG_ERASED = 14'h3FFF;
  localparam logic [13:0] CFG_UNIMPL_MASK = 14'h0080;
  // Field positions in the configuration word
  localparam int BIT_BROWNOUT_EN = 6;
  localparam int BIT_POWERUP_DELAY_TIMER_EN_N = 3;
  localparam int BIT_WATCHDOG_EN = 2;
  localparam int OSC_SEL_LSB = 0;
  localparam int CP_PAIR0_LSB = 4;
  localparam int CP_PAIR1_LSB = 8;
  localparam int CP_PAIR2_LSB = 10;
  localparam int CP_PAIR3_LSB = 12;
  // Register byte offsets
  localparam logic [3:0] OFS_PROG_ADDR = 4'h0;
  localparam logic [3:0] OFS_PROG_DATA = 4'h4;
  localparam logic [3:0] OFS_STATUS = 4'h8;
  localparam logic [3:0] OFS_SLEEP_CTRL = 4'hC;
  // Reset values
  localparam logic [13:0] PROG_ADDR_RST = 14'h0000;
  // AXI responses
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  localparam logic [1:0] RESP_DECERR = 2'h3;
  // Oscillator modes
  typedef enum logic [1:0] {
    CWD_OSC_LOW_POWER_CRYSTAL = 2'h0,
    CWD_OSC_STANDARD_CRYSTAL_RESONATOR = 2'h1,
    CWD_OSC_HIGH_SPEED_CRYSTAL = 2'h2,
    CWD_OSC_RESISTOR_CAPACITOR = 2'h3
  } cwd_osc_t;
  // Code protection extent
  typedef enum logic [1:0] {
    CWD_PROT_ALL = 2'h0,
    CWD_PROT_UPPER_3Q = 2'h1,
    CWD_PROT_UPPER_HALF = 2'h2,
    CWD_PROT_NONE = 2'h3
  } cwd_prot_t;
endpackage

// File: rtl/cwd_sync.sv
// Two flip-flop synchroniser for asynchronous pins
`timescale 1ns/1ns
`default_nettype none
module cwd_sync #(
  parameter int WIDTH = 1
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_n_i,
  // Data
  input wire logic [WIDTH-1:0] async_i,
  output logic [WIDTH-1:0] sync_o
);
  logic [WIDTH-1:0] meta_reg;

  initial
  begin
    if (WIDTH < 1)
      $error("cwd_sync WIDTH must be at least 1");
  end

  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      meta_reg <= '0;
      sync_o <= '0;
    end
    else
    begin
      meta_reg <= async_i;
      sync_o <= meta_reg;
    end
  end
endmodule
`default_nettype wire

// File: rtl/cwd_delay_timer.sv
// Down counter that holds busy for a loaded number of cycles
`timescale 1ns/1ns
`default_nettype none
module cwd_delay_timer #(
  parameter int WIDTH = 21
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_n_i,
  // Control
  input wire logic start_i,
  input wire logic [WIDTH-1:0] count_i,
  output logic busy_o,
  output logic done_o
);
  logic [WIDTH-1:0] count_reg;

  initial
  begin
    if (WIDTH < 2)
      $error("cwd_delay_timer WIDTH must be at least 2");
  end

  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      count_reg <= '0;
      done_o <= 1'b0;
    end
    else if (start_i)
    begin
      count_reg <= count_i;
      done_o <= 1'b0;
    end
    else
    begin
      done_o <= (count_reg == {{(WIDTH-1){1'b0}}, 1'b1});
      if (count_reg != '0)
        count_reg <= count_reg - 1'b1;
    end
  end

  assign busy_o = (count_reg != '0);
endmodule
`default_nettype wire

// File: verif/cwd_programmer.sv
// Device programmer model: AXI4-Lite master and programming pin
`timescale 1ns/1ns
`default_nettype none
module cwd_programmer (
  // Clock
  input wire logic clk_i,
  // AXI4-Lite master
  output logic [3:0] awaddr_o,
  output logic awvalid_o,
  input wire logic awready_i,
  output logic [31:0] wdata_o,
  output logic [3:0] wstrb_o,
  output logic wvalid_o,
  input wire logic wready_i,
  input wire logic [1:0] bresp_i,
  input wire logic bvalid_i,
  output logic bready_o,
  output logic [3:0] araddr_o,
  output logic arvalid_o,
  input wire logic arready_i,
  input wire logic [31:0] rdata_i,
  input wire logic [1:0] rresp_i,
  input wire logic rvalid_i,
  output logic rready_o,
  // Programming pin
  output logic prog_mode_o
);
  initial
  begin
    awaddr_o = 4'h0;
    awvalid_o = 1'b0;
    wdata_o = 32'h0;
    wstrb_o = 4'hF;
    wvalid_o = 1'b0;
    bready_o = 1'b0;
    araddr_o = 4'h0;
    arvalid_o = 1'b0;
    rready_o = 1'b0;
    prog_mode_o = 1'b0;
  end

  // Every protection copy gets the same pair
  function automatic logic [13:0] make_word(input logic [1:0] cp,
    input logic bo, input logic pn, input logic wdt, input logic [1:0] osc);
    make_word = {cp, cp, cp, 1'b0, bo, cp, pn, wdt, osc};
  endfunction

  // Pin passes a two-flop synchroniser, so settle before access
  task automatic set_mode(input logic m);
    @(posedge clk_i);
    prog_mode_o <= m;
    repeat (3) @(posedge clk_i);
  endtask

  task automatic wr(input logic [3:0] a, input logic [31:0] d,
    output logic [1:0] r);
    @(posedge clk_i);
    awaddr_o <= a;
    wdata_o <= d;
    awvalid_o <= 1'b1;
    wvalid_o <= 1'b1;
    bready_o <= 1'b1;
    do
    begin
      @(posedge clk_i);
      if (awready_i === 1'b1)
        awvalid_o <= 1'b0;
      if (wready_i === 1'b1)
        wvalid_o <= 1'b0;
    end while (bvalid_i !== 1'b1);
    r = bresp_i;
    bready_o <= 1'b0;
  endtask

  task automatic rd(input logic [3:0] a, output logic [31:0] d,
    output logic [1:0] r);
    @(posedge clk_i);
    araddr_o <= a;
    arvalid_o <= 1'b1;
    rready_o <= 1'b1;
    do
    begin
      @(posedge clk_i);
      if (arready_i === 1'b1)
        arvalid_o <= 1'b0;
    end while (rvalid_i !== 1'b1);
    d = rdata_i;
    r = rresp_i;
    rready_o <= 1'b0;
  endtask

  // Only programming mode may reach the word
  task automatic prog(input logic [13:0] w, output logic [31:0] rb,
    output logic [1:0] r);
    logic [1:0] ra;
    set_mode(1'b1);
    wr(cwd_pkg::OFS_PROG_ADDR, {18'h0, cwd_pkg::CFG_WORD_ADDR}, ra);
    wr(cwd_pkg::OFS_PROG_DATA, {18'h0, w}, r);
    rd(cwd_pkg::OFS_PROG_DATA, rb, ra);
    set_mode(1'b0);
  endtask
endmodule
`default_nettype wire

// File: verif/tb.sv
// Self-checking bench for the configuration word decoder
`timescale 1ns/1ns
`default_nettype none
module tb;
  // Short counts keep the run brief
  localparam int POWERUP_DELAY_TIMER_C = 20;
  localparam int OST_C = 8;
  logic clk, rst_n, ext_rst, bo_pin, wdt_to, irq, prog;
  logic [3:0] awaddr, araddr, wstrb;
  logic [31:0] wdata, rdata;
  logic awvalid, awready, wvalid, wready, bvalid, bready;
  logic arvalid, arready, rvalid, rready;
  logic [1:0] bresp, rresp, osc, prot;
  logic dev_rst, sleep, bo_en, powerup_delay_timer_on, wdt_en, mism;
  logic [7:0] ctl;
  int failures = 0;
  int cmp_count = 0;
  int cyc = 0;
  assign ctl = {bo_en, powerup_delay_timer_on, wdt_en, osc, prot, mism};

  cwd_config_word_decoder #(.POWERUP_DELAY_TIMER_CYCLES(POWERUP_DELAY_TIMER_C), .OST_CYCLES(OST_C),
    .TMR_W(21)) i_dut (.clk_i(clk), .rst_n_i(rst_n),
    .s_axi_awaddr_i(awaddr), .s_axi_awvalid_i(awvalid),
    .s_axi_awready_o(awready), .s_axi_wdata_i(wdata),
    .s_axi_wstrb_i(wstrb), .s_axi_wvalid_i(wvalid),
    .s_axi_wready_o(wready), .s_axi_bresp_o(bresp),
    .s_axi_bvalid_o(bvalid), .s_axi_bready_i(bready),
    .s_axi_araddr_i(araddr), .s_axi_arvalid_i(arvalid),
    .s_axi_arready_o(arready), .s_axi_rdata_o(rdata),
    .s_axi_rresp_o(rresp), .s_axi_rvalid_o(rvalid),
    .s_axi_rready_i(rready), .prog_mode_i(prog), .ext_reset_i(ext_rst),
    .brownout_i(bo_pin), .watchdog_timeout_i(wdt_to), .irq_i(irq),
    .device_reset_o(dev_rst), .sleep_o(sleep),
    .brownout_reset_en_o(bo_en), .powerup_timer_on_o(powerup_delay_timer_on),
    .watchdog_en_o(wdt_en), .osc_mode_sel_o(osc),
    .protect_level_o(prot), .cp_mismatch_o(mism));

  cwd_programmer i_prog (.clk_i(clk), .awaddr_o(awaddr),
    .awvalid_o(awvalid), .awready_i(awready), .wdata_o(wdata),
    .wstrb_o(wstrb), .wvalid_o(wvalid), .wready_i(wready),
    .bresp_i(bresp), .bvalid_i(bvalid), .bready_o(bready),
    .araddr_o(araddr), .arvalid_o(arvalid), .arready_i(arready),
    .rdata_i(rdata), .rresp_i(rresp), .rvalid_i(rvalid),
    .rready_o(rready), .prog_mode_o(prog));

  initial
  begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  task automatic check(input string name, input logic [31:0] seen,
    input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp)
    begin
      failures++;
      $display("BAD %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic finish_test();
    $display("Comparisons %0d mismatches %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  // Mismatched copies fall back to no protection
  function automatic logic [7:0] exp_ctl(input logic [13:0] w);
    logic bad;
    bad = w[13:12] != w[5:4] || w[11:10] != w[5:4] || w[9:8] != w[5:4];
    exp_ctl = {w[6], w[6] | ~w[3], w[2], w[1:0], bad ? 2'h3 : w[5:4], bad};
  endfunction

  task automatic wait_run(output int n);
    n = 0;
    while (dev_rst !== 1'b0 && n < 200)
    begin
      @(posedge clk);
      n++;
    end
  endtask

  task automatic t_power();
    int n;
    wait_run(n);
    check("powerup_delay_timer_len", n >= POWERUP_DELAY_TIMER_C && n < POWERUP_DELAY_TIMER_C + 10, 1'b1);
    check("erased_ctl", ctl, exp_ctl(14'h3FFF));
  endtask

  task automatic t_access();
    logic [31:0] d;
    logic [1:0] r;
    i_prog.wr(cwd_pkg::OFS_PROG_DATA, 32'h0, r);
    check("wr_nomode", r, cwd_pkg::RESP_SLVERR);
    i_prog.set_mode(1'b1);
    i_prog.wr(cwd_pkg::OFS_PROG_ADDR, 32'h1FFF, r);
    i_prog.rd(cwd_pkg::OFS_PROG_DATA, d, r);
    check("below_resp", r, cwd_pkg::RESP_SLVERR);
    check("below_data", d, 32'h0);
    i_prog.wr(cwd_pkg::OFS_PROG_ADDR, 32'h2007, r);
    i_prog.rd(cwd_pkg::OFS_PROG_DATA, d, r);
    check("erased_word", d, 32'h3FFF);
    i_prog.rd(4'h2, d, r);
    check("unmapped", r, cwd_pkg::RESP_DECERR);
    i_prog.set_mode(1'b0);
    i_prog.rd(cwd_pkg::OFS_PROG_DATA, d, r);
    check("rd_nomode", r, cwd_pkg::RESP_SLVERR);
  endtask

  // Every oscillator and protection code, with a broken copy just before the last
  task automatic t_decode();
    logic [13:0] tbl [5];
    logic [13:0] prev;
    logic [31:0] d;
    logic [1:0] r;
    int n;
    tbl[0] = i_prog.make_word(2'h0, 1'b0, 1'b0, 1'b0, 2'h0);
    tbl[1] = i_prog.make_word(2'h1, 1'b1, 1'b1, 1'b0, 2'h1);
    tbl[2] = i_prog.make_word(2'h2, 1'b0, 1'b1, 1'b1, 2'h2);
    tbl[3] = i_prog.make_word(2'h3, 1'b0, 1'b0, 1'b1, 2'h3) ^ 14'h1000;
    tbl[4] = i_prog.make_word(2'h3, 1'b0, 1'b0, 1'b1, 2'h3);
    prev = 14'h3FFF;
    foreach (tbl[i])
    begin
      i_prog.prog(tbl[i], d, r);
      check("wr_resp", r, cwd_pkg::RESP_OKAY);
      check("readback", d, {18'h0, tbl[i] | 14'h0080});
      check("hold", ctl, exp_ctl(prev));
      ext_rst <= 1'b1;
      repeat (5) @(posedge clk);
      check("ext_rst", dev_rst, 1'b1);
      ext_rst <= 1'b0;
      wait_run(n);
      // Crystal modes wait for the start-up timer, none reruns POWERUP_DELAY_TIMER
      check("restart", n < POWERUP_DELAY_TIMER_C && (n >= OST_C) == (tbl[i][1:0] != 2'h3),
        1'b1);
      check("ctl", ctl,
        exp_ctl(tbl[i]));
      bo_pin <= 1'b1;
      repeat (5) @(posedge clk);
      check("bo_rst", dev_rst, tbl[i][6]);
      bo_pin <= 1'b0;
      wait_run(n);
      prev = tbl[i];
    end
  endtask

  // Wake by interrupt, watchdog, then external reset
  task automatic t_sleep();
    logic [1:0] r;
    int n;
    for (int k = 0; k < 3; k++)
    begin
      i_prog.wr(cwd_pkg::OFS_SLEEP_CTRL, 32'h1, r);
      repeat (2) @(posedge clk);
      check("asleep", sleep, 1'b1);
      {ext_rst, wdt_to, irq} <= 3'(1 << k);
      n = 0;
      while (sleep !== 1'b0 && n < 8)
      begin
        @(posedge clk);
        n++;
      end
      check("woken", n < 8, 1'b1);
      {ext_rst, wdt_to, irq} <= 3'h0;
      wait_run(n);
    end
  endtask

  always @(posedge clk)
  begin
    cyc <= cyc + 1;
    if (cyc == 20000)
    begin
      failures = failures + 1;
      finish_test();
    end
  end

  initial
  begin
    rst_n = 1'b0;
    ext_rst = 1'b0;
    bo_pin = 1'b0;
    wdt_to = 1'b0;
    irq = 1'b0;
    repeat (12) @(posedge clk);
    rst_n <= 1'b1;
    t_power();
    t_access();
    t_decode();
    t_sleep();
    finish_test();
  end
endmodule
`default_nettype wire
